// *** core/uart_modem_status_baud_fifo_irq.sv ***
// serial port register file, modem status, fifos and interrupt logic
`include "uart_cfg.svh"
`default_nettype none
module uart_modem_status_baud_fifo_irq #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic clear_to_send_n,
   input wire logic data_set_ready_n,
   input wire logic ring_indicator_n,
   input wire logic carrier_detect_n,
   output logic data_terminal_ready_n,
   output logic request_to_send_n,
   output logic serialIrq,
   input wire logic [1:0] refSelect,
   output logic baudTick,
   output logic [7:0] lineCtl,
   input wire logic rxCharValid,
   input wire logic [7:0] rxCharData,
   input wire logic [2:0] rxCharErr,
   input wire logic txCharReq,
   output logic txCharAvail,
   output logic [7:0] txCharData,
   input wire logic txShiftIdle
);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE = (AW+1)'(1);
   uart_pkg::byte_t lcr_q, ier_q, scr_q, dll_q, dlm_q, fcr_q, rdData_q, txData_q;
   logic [4:0] mcr_q;
   logic divisor_access_bit, fifoEn, fifoFlip, rxClr, txClr, divReload_q;
   logic wrDll, wrDlm, wrThr, wrIer, wrFcr, wrLcr, wrMcr, wrScr;
   logic rdRbr, rdIir, rdLsr, rdMsr;
   logic [7:0] rdView [8];
   // ----------------------------------------
   // address decode
   // ----------------------------------------
   assign divisor_access_bit = lcr_q[`LC_DIV_ACCESS];
   assign wrDll = regWr & (regAddr == `OFS_DATA) & divisor_access_bit;
   assign wrThr = regWr & (regAddr == `OFS_DATA) & ~divisor_access_bit;
   assign wrDlm = regWr & (regAddr == `OFS_IEN) & divisor_access_bit;
   assign wrIer = regWr & (regAddr == `OFS_IEN) & ~divisor_access_bit;
   assign wrFcr = regWr & (regAddr == `OFS_IDENT);
   assign wrLcr = regWr & (regAddr == `OFS_LINECTL);
   assign wrMcr = regWr & (regAddr == `OFS_MODEMCTL);
   assign wrScr = regWr & (regAddr == `OFS_SCRATCH);
   assign rdRbr = regRd & (regAddr == `OFS_DATA) & ~divisor_access_bit;
   assign rdIir = regRd & (regAddr == `OFS_IDENT);
   assign rdLsr = regRd & (regAddr == `OFS_LINESTATE);
   assign rdMsr = regRd & (regAddr == `OFS_MODEMSTATE);
   assign fifoEn = fcr_q[`FC_ENABLE];
   assign fifoFlip = wrFcr & (regWrData[`FC_ENABLE] != fifoEn);
   assign rxClr = fifoFlip | (wrFcr & regWrData[`FC_RX_RESET]);
   assign txClr = fifoFlip | (wrFcr & regWrData[`FC_TX_RESET]);
   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lcr_q <= 8'h00;
         ier_q <= 8'h00;
         scr_q <= 8'h00;
         dll_q <= 8'h00;
         dlm_q <= 8'h00;
         fcr_q <= 8'h00;
         mcr_q <= 5'h00;
         divReload_q <= 1'b0;
      end else begin
         divReload_q <= wrDll | wrDlm;
         if (wrLcr) lcr_q <= regWrData;
         if (wrIer) ier_q <= {4'h0, regWrData[3:0]};
         if (wrScr) scr_q <= regWrData;
         if (wrDll) dll_q <= regWrData;
         if (wrDlm) dlm_q <= regWrData;
         if (wrFcr) fcr_q <= {regWrData[7:6], 5'h00, regWrData[`FC_ENABLE]};
         if (wrMcr) mcr_q <= regWrData[4:0];
      end
   end
   assign lineCtl = lcr_q;
   // ----------------------------------------
   // baud divider
   // ----------------------------------------
   baud_if baudBus ();
   assign baudBus.divisor = {dlm_q, dll_q};
   assign baudBus.reload = divReload_q;
   assign baudBus.refSel = uart_pkg::ref_sel_t'(refSelect);
   assign baudTick = baudBus.baudTick;
   baud_divider divider (
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(baudBus)
   );
   // ----------------------------------------
   // modem status
   // ----------------------------------------
   logic [3:0] syncA_q, syncB_q, msIn, msPrev_q, delta_q, deltaSet;
   logic loop;
   assign loop = mcr_q[`MC_LOOP];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncA_q <= 4'hf;
         syncB_q <= 4'hf;
         msPrev_q <= 4'h0;
         delta_q <= 4'h0;
      end else begin
         syncA_q <= {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n};
         syncB_q <= syncA_q;
         msPrev_q <= msIn;
         delta_q <= (rdMsr ? 4'h0 : delta_q) | deltaSet;
      end
   end
   assign msIn = loop ? {mcr_q[`MC_IRQ_GATE_OUTPUT], mcr_q[`MC_USER_OUTPUT_ONE], mcr_q[`MC_DTR], mcr_q[`MC_RTS]}
                      : ~syncB_q;
   assign deltaSet[0] = msIn[0] ^ msPrev_q[0];
   assign deltaSet[1] = msIn[1] ^ msPrev_q[1];
   assign deltaSet[2] = msPrev_q[2] & ~msIn[2];
   assign deltaSet[3] = msIn[3] ^ msPrev_q[3];
   assign data_terminal_ready_n = loop | ~mcr_q[`MC_DTR];
   assign request_to_send_n = loop | ~mcr_q[`MC_RTS];
   // ----------------------------------------
   // receive fifo
   // ----------------------------------------
   uart_pkg::rx_entry_t rxMem [DEPTH];
   uart_pkg::rx_entry_t rxHead;
   logic [AW-1:0] rxWr_q, rxRd_q;
   logic [AW:0] rxCnt_q;
   logic rxEmpty, rxFull, rxPush, rxPop, rxOver, rxAnyErr, headNew_q, headNew;
   assign rxEmpty = (rxCnt_q == '0);
   assign rxFull = fifoEn ? (rxCnt_q == FULL) : ~rxEmpty;
   assign rxPush = rxCharValid & ~rxFull;
   assign rxOver = rxCharValid & rxFull;
   assign rxPop = rdRbr & ~rxEmpty;
   assign rxHead = rxMem[rxRd_q];
   assign headNew = rxPop ? ((rxCnt_q > ONE) | rxPush) : (rxPush & rxEmpty);
   always_ff @(posedge clk) begin
      if (rxPush) rxMem[rxWr_q] <= '{err: rxCharErr, data: rxCharData};
   end
   always_ff @(posedge clk) begin
      if (sys_rst | rxClr) begin
         rxWr_q <= '0;
         rxRd_q <= '0;
         rxCnt_q <= '0;
         headNew_q <= 1'b0;
      end else begin
         rxWr_q <= rxWr_q + AW'(rxPush);
         rxRd_q <= rxRd_q + AW'(rxPop);
         rxCnt_q <= rxCnt_q + (AW+1)'(rxPush) - (AW+1)'(rxPop);
         headNew_q <= headNew;
      end
   end
   always_comb begin
      rxAnyErr = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         if ((AW+1)'(AW'(i) - rxRd_q) < rxCnt_q) rxAnyErr = rxAnyErr | (|rxMem[i].err);
      end
   end
   // ----------------------------------------
   // line status
   // ----------------------------------------
   logic [3:0] lsrErr_q;
   logic tx_hold_empty, temt;
   logic [7:0] line_state_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lsrErr_q <= 4'h0;
      end else begin
         lsrErr_q <= (rdLsr ? 4'h0 : lsrErr_q) | {headNew_q ? rxHead.err : 3'h0, rxOver};
      end
   end
   assign line_state_reg = {fifoEn & rxAnyErr, temt, tx_hold_empty, lsrErr_q, ~rxEmpty};
   // ----------------------------------------
   // receive timeout
   // ----------------------------------------
   logic [3:0] charBits;
   logic [7:0] charTicks;
   logic [9:0] tmoCnt_q, tmoLimit;
   logic tmoAct_q;
   assign charBits = `CHAR_BASE_BITS + {2'h0, lcr_q[1:0]} + {3'h0, lcr_q[`LC_PARITY]}
                     + {3'h0, lcr_q[`LC_STOP]};
   assign charTicks = 8'(charBits * `TICKS_PER_BIT);
   assign tmoLimit = 10'(`TMO_CHARS * {2'h0, charTicks});
   always_ff @(posedge clk) begin
      if (sys_rst | rxClr | rxPush | rxPop) begin
         tmoCnt_q <= 10'h000;
      end else if (baudTick && tmoCnt_q < tmoLimit) begin
         tmoCnt_q <= tmoCnt_q + 10'h001;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst | rxClr | rxPop) begin
         tmoAct_q <= 1'b0;
      end else if (fifoEn && !rxEmpty && tmoCnt_q >= tmoLimit) begin
         tmoAct_q <= 1'b1;
      end
   end
   // ----------------------------------------
   // transmit fifo
   // ----------------------------------------
   uart_pkg::byte_t txMem [DEPTH];
   logic [AW-1:0] txWr_q, txRd_q;
   logic [AW:0] txCnt_q;
   logic [7:0] txDly_q;
   logic [3:0] irqId;
   logic txEmpty, txFull, txPush, txPop, txGoEmpty, twoSeen_q, threPrev_q, threRise, thrIrq_q;
   assign txEmpty = (txCnt_q == '0);
   assign txFull = fifoEn ? (txCnt_q == FULL) : ~txEmpty;
   assign txPush = wrThr & ~txFull;
   assign txPop = txCharReq & ~txEmpty;
   assign txGoEmpty = txPop & (txCnt_q == ONE) & ~txPush;
   assign txCharAvail = ~txEmpty;
   assign txCharData = txData_q;
   always_ff @(posedge clk) begin
      if (txPush) txMem[txWr_q] <= regWrData;
   end
   always_ff @(posedge clk) begin
      if (sys_rst | txClr) begin
         txWr_q <= '0;
         txRd_q <= '0;
         txCnt_q <= '0;
      end else begin
         txWr_q <= txWr_q + AW'(txPush);
         txRd_q <= txRd_q + AW'(txPop);
         txCnt_q <= txCnt_q + (AW+1)'(txPush) - (AW+1)'(txPop);
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txData_q <= 8'h00;
      end else if (txPop) begin
         txData_q <= txMem[txRd_q];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst | txClr | txPush) begin
         txDly_q <= 8'h00;
      end else if (txGoEmpty & fifoEn & ~twoSeen_q) begin
         txDly_q <= charTicks - `TICKS_PER_BIT;
      end else if (baudTick && txDly_q != 8'h00) begin
         txDly_q <= txDly_q - 8'h01;
      end
   end
   assign tx_hold_empty = txEmpty & (txDly_q == 8'h00);
   assign temt = tx_hold_empty & txShiftIdle;
   assign threRise = tx_hold_empty & ~threPrev_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         threPrev_q <= 1'b0;
         twoSeen_q <= 1'b0;
         thrIrq_q <= 1'b0;
      end else begin
         threPrev_q <= tx_hold_empty & ~fifoFlip;
         twoSeen_q <= (txCnt_q >= (AW+1)'(2)) | (twoSeen_q & ~threRise);
         thrIrq_q <= threRise | (thrIrq_q & ~(wrThr | (rdIir && irqId == `ID_THR)));
      end
   end
   // ----------------------------------------
   // interrupt identification
   // ----------------------------------------
   logic [4:0] trig;
   logic lineIrq, rdaIrq, tmoIrq, thIrq, msIrq;
   assign trig = (fcr_q[7:6] == 2'h0) ? `TRIG_0 : (fcr_q[7:6] == 2'h1) ? `TRIG_1 :
                 (fcr_q[7:6] == 2'h2) ? `TRIG_2 : `TRIG_3;
   assign lineIrq = ier_q[`IE_LINE] & (|lsrErr_q);
   assign rdaIrq = ier_q[`IE_RDA] & (fifoEn ? (rxCnt_q >= trig) : ~rxEmpty);
   assign tmoIrq = ier_q[`IE_RDA] & tmoAct_q;
   assign thIrq = ier_q[`IE_THR] & thrIrq_q;
   assign msIrq = ier_q[`IE_MODEM] & (|delta_q);
   assign irqId = lineIrq ? `ID_LINE : rdaIrq ? `ID_RDA : tmoIrq ? `ID_TMO :
                  thIrq ? `ID_THR : msIrq ? `ID_MODEM : `ID_NONE;
   assign serialIrq = (irqId != `ID_NONE) & mcr_q[`MC_IRQ_GATE_OUTPUT];
   // ----------------------------------------
   // read path
   // ----------------------------------------
   assign rdView[0] = divisor_access_bit ? dll_q : rxHead.data;
   assign rdView[1] = divisor_access_bit ? dlm_q : ier_q;
   assign rdView[2] = {fifoEn, fifoEn, 2'h0, irqId};
   assign rdView[3] = lcr_q;
   assign rdView[4] = {3'h0, mcr_q};
   assign rdView[5] = line_state_reg;
   assign rdView[6] = {msIn, delta_q};
   assign rdView[7] = scr_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData_q <= 8'h00;
      end else if (regRd) begin
         rdData_q <= rdView[regAddr];
      end
   end
   assign regRdData = rdData_q;
endmodule
`default_nettype wire

// *** core/uart_cfg.svh ***
// offsets, bit positions, codes and timing constants of the serial port
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_DATA 3'h0
`define OFS_IEN 3'h1
`define OFS_IDENT 3'h2
`define OFS_LINECTL 3'h3
`define OFS_MODEMCTL 3'h4
`define OFS_LINESTATE 3'h5
`define OFS_MODEMSTATE 3'h6
`define OFS_SCRATCH 3'h7
// ----------------------------------------
// field positions
// ----------------------------------------
`define LC_DIV_ACCESS 7
`define LC_STOP 2
`define LC_PARITY 3
`define MC_DTR 0
`define MC_RTS 1
`define MC_USER_OUTPUT_ONE 2
`define MC_IRQ_GATE_OUTPUT 3
`define MC_LOOP 4
`define FC_ENABLE 0
`define FC_RX_RESET 1
`define FC_TX_RESET 2
`define IE_RDA 0
`define IE_THR 1
`define IE_LINE 2
`define IE_MODEM 3
// ----------------------------------------
// identification codes
// ----------------------------------------
`define ID_NONE 4'h1
`define ID_LINE 4'h6
`define ID_RDA 4'h4
`define ID_TMO 4'hc
`define ID_THR 4'h2
`define ID_MODEM 4'h0
// ----------------------------------------
// trigger levels and timing
// ----------------------------------------
`define TRIG_0 5'h01
`define TRIG_1 5'h04
`define TRIG_2 5'h08
`define TRIG_3 5'h0e
`define CHAR_BASE_BITS 4'h6
`define TICKS_PER_BIT 8'h10
`define TMO_CHARS 10'h004
`define CLK_HZ 64'h0bebc200
`define REF_SLOW_HZ 64'h001c2bb8
`define REF_STD_HZ 64'h001c2000
`define REF_DOUBLE_HZ 64'h00384000
`define REF_QUAD_HZ 64'h00708000
`define ACC_SHIFT 32
`endif

// *** core/uart_pkg.sv ***
// types shared by the serial port modules
`default_nettype none
package uart_pkg;
   typedef logic [7:0] byte_t;
   typedef struct packed {
      logic [2:0] err;
      byte_t data;
   } rx_entry_t;
   typedef enum logic [1:0] {REF_SLOW, REF_STD, REF_DOUBLE, REF_QUAD} ref_sel_t;
endpackage
`default_nettype wire

// *** core/baud_if.sv ***
// carrier between register file and baud divider
`default_nettype none
interface baud_if;
   logic [15:0] divisor;
   logic reload;
   uart_pkg::ref_sel_t refSel;
   logic baudTick;
   modport ctrl (output divisor, output reload, output refSel, input baudTick);
   modport gen (input divisor, input reload, input refSel, output baudTick);
endinterface
`default_nettype wire

// *** core/baud_divider.sv ***
// reference clock synthesis and programmable 16x baud divider
`include "uart_cfg.svh"
`default_nettype none
module baud_divider (
   input wire logic clk,
   input wire logic sys_rst,
   baud_if.gen bus
);
   localparam logic [31:0] INC_SLOW = 32'((`REF_SLOW_HZ << `ACC_SHIFT) / `CLK_HZ);
   localparam logic [31:0] INC_STD = 32'((`REF_STD_HZ << `ACC_SHIFT) / `CLK_HZ);
   localparam logic [31:0] INC_DOUBLE = 32'((`REF_DOUBLE_HZ << `ACC_SHIFT) / `CLK_HZ);
   localparam logic [31:0] INC_QUAD = 32'((`REF_QUAD_HZ << `ACC_SHIFT) / `CLK_HZ);
   logic [31:0] acc_q, accNext, inc;
   logic [15:0] cnt_q, cnt_d, div;
   logic tog_q, level, levelPrev_q, tick_q, refRise;
   // ----------------------------------------
   // reference clock
   // ----------------------------------------
   assign inc = (bus.refSel == uart_pkg::REF_SLOW) ? INC_SLOW :
                (bus.refSel == uart_pkg::REF_STD) ? INC_STD :
                (bus.refSel == uart_pkg::REF_DOUBLE) ? INC_DOUBLE : INC_QUAD;
   assign accNext = acc_q + inc;
   assign refRise = ~acc_q[31] & accNext[31];
   // ----------------------------------------
   // divider
   // ----------------------------------------
   assign div = bus.divisor;
   assign cnt_d = (div == 16'h0000) ? ((cnt_q == 16'h0002) ? 16'h0000 : cnt_q + 16'h0001) :
                  (cnt_q == 16'h0000) ? div - 16'h0001 : cnt_q - 16'h0001;
   assign level = (div == 16'h0000) ? (cnt_q != 16'h0000) :
                  (div == 16'h0001) ? ~acc_q[31] :
                  (div == 16'h0002) ? tog_q : (cnt_q < div - 16'h0002);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_q <= 32'h00000000;
      end else begin
         acc_q <= accNext;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst | bus.reload) begin
         cnt_q <= (bus.reload && div > 16'h0002) ? div - 16'h0001 : 16'h0000;
         tog_q <= 1'b0;
      end else if (refRise) begin
         cnt_q <= cnt_d;
         tog_q <= ~tog_q;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         levelPrev_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         levelPrev_q <= level;
         tick_q <= level & ~levelPrev_q;
      end
   end
   assign bus.baudTick = tick_q;
endmodule
`default_nettype wire

// *** test/uart_modem_status_baud_fifo_irq_assertions.sv ***
// concurrent checks on the serial port top-level ports
`default_nettype none
module uart_port_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic clear_to_send_n,
   input wire logic data_set_ready_n,
   input wire logic ring_indicator_n,
   input wire logic carrier_detect_n,
   input wire logic data_terminal_ready_n,
   input wire logic request_to_send_n,
   input wire logic serialIrq,
   input wire logic baudTick,
   input wire logic [7:0] lineCtl,
   input wire logic rxCharValid,
   input wire logic txCharAvail
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------
   // shadow state
   // ----------------
   logic [7:0] scrQ;
   logic [7:0] divHiQ;
   logic [4:0] mcQ;
   logic [3:0] ieQ;
   logic [3:0] pinsQ;
   logic [2:0] quietQ;
   wire logic [3:0] pins = {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n};
   wire logic [2:0] quietD = (pins != pinsQ) ? 3'h0 : (quietQ == 3'h7) ? 3'h7 : quietQ + 3'h1;
   wire logic wrHi = regWr && regAddr == 3'h1;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scrQ <= 8'h00;
         divHiQ <= 8'h00;
         mcQ <= 5'h00;
         ieQ <= 4'h0;
         pinsQ <= 4'hf;
         quietQ <= 3'h0;
      end else begin
         pinsQ <= pins;
         quietQ <= quietD;
         if (regWr && regAddr == 3'h7) scrQ <= regWrData;
         if (regWr && regAddr == 3'h4) mcQ <= regWrData[4:0];
         if (wrHi && !lineCtl[7]) ieQ <= regWrData[3:0];
         if (wrHi && lineCtl[7]) divHiQ <= regWrData;
      end
   end
   // ----------------
   // properties
   // ----------------
   scratch_readback_a: assert property (
      (regRd && regAddr == 3'h7 && !regWr) |=> regRdData == $past(scrQ))
      else $error("scratch readback differs");
   loop_status_a: assert property (
      (regRd && regAddr == 3'h6 && mcQ[4]) |=> regRdData[7:4] == $past({mcQ[3:2], mcQ[0], mcQ[1]}))
      else $error("loopback status bits wrong");
   live_status_a: assert property (
      (regRd && regAddr == 3'h6 && !mcQ[4] && quietQ == 3'h7) |=> regRdData[7:4] == ~$past(pins))
      else $error("modem level bits wrong");
   loop_pins_a: assert property (
      mcQ[4] |-> data_terminal_ready_n && request_to_send_n)
      else $error("modem pins not idle in loopback");
   ctl_pins_a: assert property (
      !mcQ[4] |-> data_terminal_ready_n == !mcQ[0] && request_to_send_n == !mcQ[1])
      else $error("modem pins do not follow control");
   irq_gate_a: assert property (
      !mcQ[3] |-> !serialIrq)
      else $error("interrupt escapes gate");
   modem_irq_a: assert property (
      ($changed(clear_to_send_n) && ieQ[3] && mcQ[3] && !mcQ[4]) |-> ##[1:5] serialIrq)
      else $error("send clear change raised no interrupt");
   tick_pulse_a: assert property (
      baudTick |=> !baudTick)
      else $error("baud tick wider than a cycle");
   div_reload_a: assert property (
      (regWr && lineCtl[7] && regAddr == 3'h0 && regWrData <= 8'h08 && divHiQ == 8'h00)
      |-> ##[1:1000] baudTick)
      else $error("short divisor gave no tick");
   tx_avail_a: assert property (
      (regWr && regAddr == 3'h0 && !lineCtl[7]) |=> txCharAvail)
      else $error("holding write left fifo empty");
   rx_ready_a: assert property (
      (rxCharValid && !regWr) ##1 !(regRd && regAddr == 3'h0) ##1 (regRd && regAddr == 3'h5)
      |=> regRdData[0])
      else $error("data ready missing after push");
   cover property (regRd && regAddr == 3'h6 && mcQ[4]);
   cover property ($rose(serialIrq));
   cover property (baudTick ##[1:400] baudTick);
endmodule
`default_nettype wire

// *** test/modem_partner.sv ***
// data set model answering the terminal's handshake after a chosen lag
`default_nettype none
module modem_partner (
   input wire logic clk,
   input wire logic dtrN,
   input wire logic rtsN,
   input wire logic [1:0] lineEvents,
   input wire logic [3:0] lag,
   output logic clear_to_send_n,
   output logic data_set_ready_n,
   output logic ring_indicator_n,
   output logic carrier_detect_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] dtrHist = 16'hffff;
   logic [15:0] rtsHist = 16'hffff;
   always @(posedge clk) begin
      dtrHist <= {dtrHist[14:0], dtrN};
      rtsHist <= {rtsHist[14:0], rtsN};
   end
   // ready and clear follow the terminal's requests
   assign data_set_ready_n = dtrHist[lag];
   assign clear_to_send_n = rtsHist[lag];
   assign ring_indicator_n = ~lineEvents[0];
   assign carrier_detect_n = ~lineEvents[1];
endmodule
`default_nettype wire

// *** test/uart_modem_status_baud_fifo_irq_tb.sv ***
// self-checking bench for the serial port block
`include "uart_cfg.svh"
`default_nettype none
module uart_modem_status_baud_fifo_irq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic rxCharValid = 1'b0;
   logic txCharReq = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] rxCharData = 8'h00;
   logic [2:0] rxCharErr = 3'h0;
   logic [1:0] refSelect = 2'h0;
   logic [1:0] lineEvents = 2'h0;
   logic [3:0] lag = 4'h1;
   logic [7:0] regRdData, lineCtl, txCharData;
   logic clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n;
   logic data_terminal_ready_n, request_to_send_n, serialIrq, baudTick, txCharAvail;
   int num_errors = 0;
   int n_tests = 0;
   int n;
   real e;
   logic [7:0] pat [4] = '{8'h00, 8'ha5, 8'h5a, 8'hff};
   real refHz [4] = '{`REF_SLOW_HZ, `REF_STD_HZ, `REF_DOUBLE_HZ, `REF_QUAD_HZ};
   uart_modem_status_baud_fifo_irq dut_u (
      .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
      .regWrData(regWrData), .regRdData(regRdData), .clear_to_send_n(clear_to_send_n),
      .data_set_ready_n(data_set_ready_n), .ring_indicator_n(ring_indicator_n),
      .carrier_detect_n(carrier_detect_n), .data_terminal_ready_n(data_terminal_ready_n),
      .request_to_send_n(request_to_send_n), .serialIrq(serialIrq), .refSelect(refSelect),
      .baudTick(baudTick), .lineCtl(lineCtl), .rxCharValid(rxCharValid),
      .rxCharData(rxCharData), .rxCharErr(rxCharErr), .txCharReq(txCharReq),
      .txCharAvail(txCharAvail), .txCharData(txCharData), .txShiftIdle(1'b1));
   modem_partner partner_u (
      .clk(clk), .dtrN(data_terminal_ready_n), .rtsN(request_to_send_n),
      .lineEvents(lineEvents), .lag(lag), .clear_to_send_n(clear_to_send_n),
      .data_set_ready_n(data_set_ready_n), .ring_indicator_n(ring_indicator_n),
      .carrier_detect_n(carrier_detect_n));
   // ----------------
   // access tasks
   // ----------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      idle(1);
      regWr = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk) #1;
      regAddr = a;
      regRd = 1'b1;
      idle(1);
      regRd = 1'b0;
      check(regRdData & m, exp);
   endtask
   task automatic rxPush(input logic [7:0] d);
      @(posedge clk) #1;
      rxCharData = d;
      rxCharValid = 1'b1;
      idle(1);
      rxCharValid = 1'b0;
   endtask
   task automatic tickSpan(output int c);
      c = 0;
      while (baudTick !== 1'b1 && c < 2000) begin
         idle(1);
         c++;
      end
      c = 0;
      repeat (4) begin
         idle(1);
         c++;
         while (baudTick !== 1'b1 && c < 8000) begin
            idle(1);
            c++;
         end
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----------------
   // stimulus
   // ----------------
   initial begin
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (80000) @(posedge clk);
      num_errors++;
      results();
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      idle(4);
      foreach (pat[i]) begin
         wr(3'h7, pat[i]);
         rd(3'h7, 8'hff, pat[i]);
      end
      $display("test scratch done");
      rd(3'h6, 8'hff, 8'h00);
      wr(3'h4, 8'h03);
      idle(16);
      rd(3'h6, 8'hff, 8'h33);
      rd(3'h6, 8'hff, 8'h30);
      lag = 4'hc;
      wr(3'h4, 8'h01);
      rd(3'h6, 8'h11, 8'h10);
      idle(20);
      rd(3'h6, 8'hff, 8'h21);
      lag = 4'h1;
      lineEvents = 2'h1;
      idle(6);
      rd(3'h6, 8'hff, 8'h60);
      lineEvents = 2'h0;
      idle(6);
      rd(3'h6, 8'hff, 8'h24);
      lineEvents = 2'h2;
      idle(6);
      rd(3'h6, 8'hff, 8'ha8);
      lineEvents = 2'h0;
      idle(6);
      rd(3'h6, 8'hff, 8'h28);
      wr(3'h1, 8'h08);
      wr(3'h4, 8'h0b);
      idle(8);
      check({7'h0, serialIrq}, 8'h01);
      rd(3'h2, 8'hff, {4'h0, `ID_MODEM});
      rd(3'h6, 8'hff, 8'h31);
      idle(2);
      check({7'h0, serialIrq}, 8'h00);
      wr(3'h4, 8'h1f);
      check({6'h0, data_terminal_ready_n, request_to_send_n}, 8'h03);
      rd(3'h6, 8'hf0, 8'hf0);
      wr(3'h4, 8'h15);
      rd(3'h6, 8'hf0, 8'h60);
      wr(3'h4, 8'h00);
      wr(3'h1, 8'h00);
      rd(3'h6, 8'h00, 8'h00);
      $display("test modem done");
      wr(3'h3, 8'h80);
      for (int i = 0; i < 4; i++) begin
         refSelect = 2'(i);
         wr(3'h0, 8'(3 - i));
         wr(3'h1, 8'h00);
         tickSpan(n);
         e = 4.0 * ((i == 3) ? 3.0 : real'(3 - i)) * real'(`CLK_HZ) / refHz[i];
         check({7'h0, real'(n) > e - 3.0 && real'(n) < e + 3.0}, 8'h01);
      end
      wr(3'h3, 8'h00);
      $display("test divider done");
      wr(3'h2, 8'h41);
      wr(3'h1, 8'h01);
      wr(3'h4, 8'h08);
      for (int i = 0; i < 3; i++) rxPush(8'(8'h10 + i));
      idle(2);
      check({7'h0, serialIrq}, 8'h00);
      rxPush(8'h13);
      rd(3'h5, 8'h01, 8'h01);
      idle(2);
      check({7'h0, serialIrq}, 8'h01);
      rd(3'h2, 8'hff, 8'hc4);
      rd(3'h5, 8'h01, 8'h01);
      rd(3'h0, 8'hff, 8'h10);
      idle(2);
      check({7'h0, serialIrq}, 8'h00);
      n = 0;
      while (serialIrq !== 1'b1 && n < 40000) begin
         idle(1);
         n++;
      end
      e = 4.0 * 16.0 * 6.0 * 3.0 * real'(`CLK_HZ) / refHz[3];
      check({7'h0, real'(n) > 0.97 * e && real'(n) < 1.03 * e}, 8'h01);
      rd(3'h2, 8'hff, 8'hcc);
      rd(3'h0, 8'hff, 8'h11);
      idle(2);
      check({7'h0, serialIrq}, 8'h00);
      wr(3'h1, 8'h00);
      rd(3'h5, 8'h01, 8'h01);
      rd(3'h0, 8'hff, 8'h12);
      rd(3'h0, 8'hff, 8'h13);
      rd(3'h5, 8'h01, 8'h00);
      wr(3'h1, 8'h05);
      rxCharErr = 3'h1;
      rxPush(8'h20);
      rxCharErr = 3'h0;
      for (int i = 1; i < 4; i++) rxPush(8'(8'h20 + i));
      rd(3'h2, 8'hff, 8'hc6);
      rd(3'h5, 8'h04, 8'h04);
      rd(3'h2, 8'hff, 8'hc4);
      wr(3'h2, 8'h43);
      wr(3'h1, 8'h00);
      $display("test receive done");
      wr(3'h0, 8'h3c);
      check({7'h0, txCharAvail}, 8'h01);
      txCharReq = 1'b1;
      idle(1);
      txCharReq = 1'b0;
      check(txCharData, 8'h3c);
      check({7'h0, txCharAvail}, 8'h00);
      $display("test transmit done");
      results();
   end
endmodule
bind uart_modem_status_baud_fifo_irq uart_port_checker chk_u (
   .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
   .regWrData(regWrData), .regRdData(regRdData), .clear_to_send_n(clear_to_send_n),
   .data_set_ready_n(data_set_ready_n), .ring_indicator_n(ring_indicator_n),
   .carrier_detect_n(carrier_detect_n), .data_terminal_ready_n(data_terminal_ready_n),
   .request_to_send_n(request_to_send_n), .serialIrq(serialIrq), .baudTick(baudTick),
   .lineCtl(lineCtl), .rxCharValid(rxCharValid), .txCharAvail(txCharAvail));
`default_nettype wire
